// file: acts_defines.vh
`ifndef ACTS_DEFINES_VH
`define ACTS_DEFINES_VH
// register byte offsets on the apb bus
`define ACTS_OFF_CTRL     12'h000
`define ACTS_OFF_TRGSEL   12'h004
`define ACTS_OFF_STATUS   12'h008
// control register fields
`define ACTS_CTRL_CH_LSB  0
`define ACTS_CTRL_TWO     3
`define ACTS_CTRL_TRIGGED 4
`define ACTS_CTRL_CYCLE   5
`define ACTS_CTRL_START   6
`define ACTS_CTRL_RESET   32'h0000_0000
// trigger select field positions
`define ACTS_TS_M0G0_LSB  0
`define ACTS_TS_M1G0_LSB  4
`define ACTS_TS_M0G1_LSB  8
`define ACTS_TS_M1G1_LSB  12
`define ACTS_TS_RESET     16'h0000
// trigger source codes
`define ACTS_SRC_PIN      4'h0
`define ACTS_SRC_TROUGH   4'h1
`define ACTS_SRC_CH0      4'h2
`define ACTS_SRC_DLYA     4'h3
`define ACTS_SRC_DLYB     4'h4
`endif

// file: acts_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acts_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  conv_enable_q,
	input wire logic        conv_group_q,
	input wire logic        conv_start_q
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic hit = psel && penable;
	wire logic map = paddr == 12'h0 || paddr == 12'h4 || paddr == 12'h8;
	a_ready_always: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (pslverr |-> hit && !map)
		else $error("pslverr on mapped place");
	a_mapped_clean: assert property (hit && map |-> !pslverr)
		else $error("pslverr on mapped access");
	a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
		else $error("start pulse too long");
	a_module_mirror: assert property (
		conv_enable_q[7:4] == conv_enable_q[3:0])
		else $error("modules disagree");
	a_legal_set: assert property (conv_enable_q[3:0] inside
		{4'h0, 4'h1, 4'h3, 4'h4, 4'hc}) else $error("bad input set");
	a_group_inputs: assert property (conv_start_q && conv_group_q |->
		conv_enable_q[3:0] inside {4'h4, 4'hc}) else $error("bad group set");
	cover property (conv_start_q && conv_group_q);
	cover property (conv_start_q && conv_enable_q == 8'hcc);
	cover property (pslverr);
endmodule
bind acts_top acts_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr,
	.pready, .pslverr, .conv_enable_q, .conv_group_q, .conv_start_q);
`default_nettype wire

// file: acts_top.v
`timescale 1ns/1ps
`default_nettype none
`include "acts_defines.vh"
module acts_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        external_trigger_pin,
	input  wire        timer_capture_trough_trigger,
	input  wire        timer_ch0_compare_trigger,
	input  wire        delayed_start_request_a,
	input  wire        delayed_start_request_b,
	input  wire        conv_done,
	output reg  [7:0]  conv_enable_q,
	output reg         conv_group_q,
	output reg         conv_start_q,
	output wire        conversion_active
);
	reg  [6:0]  ctrl_q;
	reg  [15:0] trig_sel_q;
	reg  [1:0]  grp_pend_q;
	reg         scanning_q;
	reg         start_clr;
	wire [3:0]  trig;
	wire [3:0]  bad;
	wire [2:0]  chsel;
	wire        two_ch;
	wire        trigged;
	wire        wr;
	wire        rd;
	wire        hit;
	wire        start_on;
	wire        wr_ctrl;
	wire        wr_trgsel;
	wire [1:0]  grp_new;
	wire [1:0]  grp_clr;
	wire        grp_sel;
	wire        grp_take;

	assign chsel    = ctrl_q[`ACTS_CTRL_CH_LSB +: 3];
	assign two_ch   = ctrl_q[`ACTS_CTRL_TWO];
	assign trigged  = ctrl_q[`ACTS_CTRL_TRIGGED];
	assign start_on = ctrl_q[`ACTS_CTRL_START];
	// zero wait states: every access ends in its first access cycle
	assign pready   = 1'b1;
	assign wr       = psel & penable & pwrite;
	// read data is latched in the setup cycle so it stands at the access edge
	assign rd       = psel & ~penable & ~pwrite;
	assign hit      = (paddr == `ACTS_OFF_CTRL) |
	                  (paddr == `ACTS_OFF_TRGSEL) |
	                  (paddr == `ACTS_OFF_STATUS);
	assign pslverr  = psel & penable & ~hit;
	assign wr_ctrl  = wr & (paddr == `ACTS_OFF_CTRL);
	// selector writes are dropped while armed, so a running scan never
	// sees its source change half way
	assign wr_trgsel = wr & (paddr == `ACTS_OFF_TRGSEL) & ~start_on;
	assign conversion_active = scanning_q;

	// module 0 group requests; prohibited codes never latch
	assign grp_new  = {trig[2] & ~bad[2], trig[0] & ~bad[0]};
	// group 0 is served first when both are waiting
	assign grp_sel  = ~grp_pend_q[0];
	assign grp_take = start_on & two_ch & trigged & ~scanning_q &
	                  (grp_pend_q != 2'h0);
	assign grp_clr  = grp_take ? {grp_sel, ~grp_sel} : 2'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_dec
			acts_trig_dec u_dec (
				.sel                          (trig_sel_q[gi*4 +: 4]),
				.external_trigger_pin         (external_trigger_pin),
				.timer_capture_trough_trigger (timer_capture_trough_trigger),
				.timer_ch0_compare_trigger    (timer_ch0_compare_trigger),
				.delayed_start_request_a      (delayed_start_request_a),
				.delayed_start_request_b      (delayed_start_request_b),
				.trig                         (trig[gi]),
				.bad                          (bad[gi])
			);
		end
	endgenerate

	// channel enables for modules 0 (low nibble) and 1 (high nibble)
	function [7:0] chan_map;
		input [2:0] cs;
		input       trg;
		input       grp;
		reg   [3:0] m;
		begin
			m = 4'h0;
			if (!trg) begin
				case (cs)
				3'h0:    m = 4'h1;
				3'h1:    m = 4'h3;
				3'h2:    m = 4'h4;
				3'h3:    m = 4'hc;
				default: m = 4'h0;
				endcase
			end else begin
				case (cs)
				3'h0:    m = grp ? 4'h4 : 4'h1;
				3'h1:    m = grp ? 4'hc : 4'h3;
				default: m = 4'h0;
				endcase
			end
			chan_map = {m, m};
		end
	endfunction

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q     <= 7'h00;
			trig_sel_q <= `ACTS_TS_RESET;
		end else begin
			// a software write beats the end-of-pass clear
			if (wr_ctrl)
				ctrl_q <= pwdata[6:0];
			else if (start_clr)
				ctrl_q[`ACTS_CTRL_START] <= 1'b0;
			if (wr_trgsel)
				trig_sel_q <= pwdata[15:0];
		end
	end

	always @* begin
		start_clr = 1'b0;
		// single pass outside two-group trigger mode clears start at end
		if (scanning_q && conv_done && !ctrl_q[`ACTS_CTRL_CYCLE] &&
		    !(two_ch && trigged))
			start_clr = 1'b1;
	end

	// a new trigger beats the clear of the group being served
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			grp_pend_q <= 2'h0;
		else if (!start_on || !(two_ch && trigged))
			grp_pend_q <= 2'h0;
		else
			grp_pend_q <= (grp_pend_q & ~grp_clr) | grp_new;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scanning_q    <= 1'b0;
			conv_enable_q <= 8'h00;
			conv_group_q  <= 1'b0;
			conv_start_q  <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			if (!start_on) begin
				scanning_q <= 1'b0;
			end else if (two_ch && trigged) begin
				// start the group whose trigger came
				if (grp_take) begin
					scanning_q    <= 1'b1;
					conv_group_q  <= grp_sel;
					conv_enable_q <= chan_map(chsel, 1'b1, grp_sel);
					conv_start_q  <= 1'b1;
				end else if (scanning_q && conv_done)
					scanning_q <= 1'b0;
			end else if (!scanning_q) begin
				scanning_q    <= 1'b1;
				conv_group_q  <= 1'b0;
				conv_enable_q <= chan_map(chsel, 1'b0, 1'b0);
				conv_start_q  <= 1'b1;
			end else if (conv_done && ctrl_q[`ACTS_CTRL_CYCLE])
				conv_start_q <= 1'b1;
			else if (conv_done)
				scanning_q <= 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd) begin
			case (paddr)
			`ACTS_OFF_CTRL:   prdata <= {25'h0, ctrl_q};
			`ACTS_OFF_TRGSEL: prdata <= {16'h0, trig_sel_q};
			`ACTS_OFF_STATUS: prdata <= {24'h0, bad, grp_pend_q,
			                             conv_group_q, scanning_q};
			default:          prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: acts_trig_dec.v
`timescale 1ns/1ps
`default_nettype none
`include "acts_defines.vh"
// picks one trigger source by a four-bit select field
module acts_trig_dec (
	input  wire [3:0] sel,
	input  wire       external_trigger_pin,
	input  wire       timer_capture_trough_trigger,
	input  wire       timer_ch0_compare_trigger,
	input  wire       delayed_start_request_a,
	input  wire       delayed_start_request_b,
	output reg        trig,
	output reg        bad
);
	always @* begin
		trig = 1'b0;
		bad  = 1'b0;
		case (sel)
		`ACTS_SRC_PIN:    trig = external_trigger_pin;
		`ACTS_SRC_TROUGH: trig = timer_capture_trough_trigger;
		`ACTS_SRC_CH0:    trig = timer_ch0_compare_trigger;
		`ACTS_SRC_DLYA:   trig = delayed_start_request_a;
		`ACTS_SRC_DLYB:   trig = delayed_start_request_b;
		default:          bad  = 1'b1;
		endcase
	end
endmodule
`default_nettype wire

// file: acts_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
module acts_trig_src (
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [2:0] which,
	output var  logic [4:0] trg
);
	// one pulse on the chosen source, low between pulses
	always @(posedge pclk) trg <= go ? 5'h01 << which : 5'h00;
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acts_defines.vh"
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic go = 0, conv_done = 0, pready, pslverr, err, grp, stq, act;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] en;
	logic [4:0] trg;
	logic [2:0] which = 0;
	int fails = 0, tests_run = 0;
	// expected input sets, one byte per case, lowest byte first
	localparam logic [31:0] soft_exp = 32'hcc44_3311;
	localparam logic [31:0] trig_exp = 32'hcc33_4411;
	acts_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .external_trigger_pin(trg[0]),
		.timer_capture_trough_trigger(trg[1]),
		.timer_ch0_compare_trigger(trg[2]), .delayed_start_request_a(trg[3]),
		.delayed_start_request_b(trg[4]), .conv_done, .conv_enable_q(en),
		.conv_group_q(grp), .conv_start_q(stq), .conversion_active(act));
	acts_trig_src u_src (.pclk, .go, .which, .trg);
	initial forever #5 pclk = ~pclk;
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task fire(input logic [2:0] s);
		@(posedge pclk);
		which <= s;
		go <= 1;
		@(posedge pclk);
		go <= 0;
	endtask
	// waits for one start pulse, judges it, then ends the pass
	task pass(input logic [7:0] e, input logic g);
		int n;
		n = 0;
		while (stq !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(stq), 1);
		chk(32'(act), 1);
		chk(32'(en), 32'(e));
		chk(32'(grp), 32'(g));
		conv_done <= 1;
		@(posedge pclk);
		conv_done <= 0;
	endtask
	task t_soft;
		apb(0, `ACTS_OFF_CTRL, 0);
		chk(rd, `ACTS_CTRL_RESET);
		apb(0, `ACTS_OFF_TRGSEL, 0);
		chk(rd, 32'(`ACTS_TS_RESET));
		for (int c = 0; c < 4; c++) begin
			apb(1, `ACTS_OFF_CTRL, 32'h48 | c);
			pass(soft_exp[c*8 +: 8], 0);
		end
		apb(0, `ACTS_OFF_CTRL, 0);
		chk(rd & 32'h40, 0);
		chk(32'(act), 0);
	endtask
	task t_trig;
		apb(1, `ACTS_OFF_TRGSEL, 32'h0200);
		for (int c = 0; c < 2; c++) begin
			apb(1, `ACTS_OFF_CTRL, 32'h58 | c);
			fire(0);
			pass(trig_exp[c*16 +: 8], 0);
			fire(2);
			pass(trig_exp[c*16+8 +: 8], 1);
			apb(1, `ACTS_OFF_TRGSEL, 32'h3333);
			apb(0, `ACTS_OFF_TRGSEL, 0);
			chk(rd, 32'h0200);
			apb(1, `ACTS_OFF_CTRL, 0);
		end
	endtask
	// continuous scan: start stays set and each pass restarts
	task t_cont;
		apb(1, `ACTS_OFF_CTRL, 32'h69);
		pass(8'h33, 0);
		pass(8'h33, 0);
		apb(0, `ACTS_OFF_CTRL, 0);
		chk(rd, 32'h69);
		apb(1, `ACTS_OFF_CTRL, 0);
	endtask
	// a prohibited source code is flagged and never starts a group
	task t_bad;
		apb(1, `ACTS_OFF_TRGSEL, 32'h0205);
		apb(0, `ACTS_OFF_STATUS, 0);
		chk(rd & 32'hf0, 32'h10);
		apb(1, `ACTS_OFF_CTRL, 32'h58);
		fire(0);
		repeat (4) begin
			@(posedge pclk);
			chk(32'(stq), 0);
		end
		apb(1, `ACTS_OFF_CTRL, 0);
	endtask
	task finish_test;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200us;
		fails++;
		finish_test;
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_soft;
		t_trig;
		t_cont;
		t_bad;
		apb(0, 12'h00c, 0);
		chk({31'h0, err}, 1);
		chk(rd, 0);
		finish_test;
	end
endmodule
`default_nettype wire
